// ### rtl/pdb_bridge.sv
// parallel host port to serial processor debug port bridge
// assumes host, switch, cable and processor pins are asynchronous to clk
`timescale 1ns/1ps
module pdb_bridge
  import pdb_pkg::*;
#(
  parameter int  BUF_DEPTH   = 2,
  parameter int  ADDR_W      = 3,
  parameter logic READY_LEVEL = 1'h0
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        hostDataIn,
  output logic      [7:0]        hostDataOut,
  output logic                   hostDataOe_n,
  input  wire logic              hostStrobe,
  input  wire logic              hostWrite,
  input  wire logic              registerSelectLine,
  input  wire logic [ADDR_W-1:0] hostBoardAddr,
  input  wire logic [ADDR_W-1:0] boardSelectSwitch,
  input  wire logic              cableConnected,
  output logic                   hostServiceRequest,
  output logic                   hostBusy,
  output logic                   debugSerialClock,
  output logic                   debugSerialClockOe_n,
  output logic                   debugSerialIn,
  output logic                   debugSerialInOe_n,
  input  wire logic              debugSerialOut,
  input  wire logic [1:0]        freezeStatusPair,
  input  wire logic              softResetLine_n,
  input  wire logic              hardResetLine_n
);

  localparam int SYNC_W = 8 + 3 + 2 * ADDR_W + 1 + 1 + 2 + 2;
  localparam int PTR_W  = $clog2(BUF_DEPTH);

  // every pin passes two flops; the first stage is read by the second only
  logic [SYNC_W-1:0] syncMeta_q;
  logic [SYNC_W-1:0] sync_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      syncMeta_q <= {{(SYNC_W - 2){1'b0}}, 2'h3};  // processor resets idle high, no false edge
      sync_q     <= {{(SYNC_W - 2){1'b0}}, 2'h3};
    end else begin
      syncMeta_q <= {hostDataIn, hostStrobe, hostWrite, registerSelectLine, hostBoardAddr,
                     boardSelectSwitch, cableConnected, debugSerialOut, freezeStatusPair,
                     softResetLine_n, hardResetLine_n};
      sync_q     <= syncMeta_q;
    end
  end

  logic [7:0]        hDataS;
  logic              hStrobeS;
  logic              hWriteS;
  logic              hSelS;
  logic [ADDR_W-1:0] hAddrS;
  logic [ADDR_W-1:0] swAddrS;
  logic              cableS;
  logic              sdoS;
  logic [1:0]        frzS;
  logic              sresetS_n;
  logic              hresetS_n;
  assign {hDataS, hStrobeS, hWriteS, hSelS, hAddrS, swAddrS, cableS, sdoS, frzS,
          sresetS_n, hresetS_n} = sync_q;

  logic       hStrobePrev_q;
  logic       boardHit;
  logic       accStart;
  logic       resetSeen;
  logic       in_debug_flag;
  logic [1:0] divSel_q;
  logic       srqEn_q;
  logic       loop_q;
  logic       halt_q;
  logic       txCut_q;
  logic [7:0] rxData_q;
  logic [7:0] statusByte;

  assign boardHit  = cableS && (hAddrS == swAddrS);
  assign accStart  = hStrobeS && !hStrobePrev_q && boardHit;
  assign resetSeen = !sresetS_n || !hresetS_n;
  assign in_debug_flag   = &frzS;

  always_comb begin
    statusByte                                = '0;
    statusByte[CS_RESET_SEEN_BIT]             = resetSeen;
    statusByte[CS_TX_CUT_BIT]                 = txCut_q;
    statusByte[CS_IN_DEBUG_BIT]               = in_debug_flag;
    statusByte[CS_DIV_MSB:CS_DIV_LSB]         = divSel_q;
    statusByte[CS_SRQ_EN_BIT]                 = srqEn_q;
    statusByte[CS_LOOP_BIT]                   = loop_q;
    statusByte[CS_HALT_BIT]                   = halt_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hStrobePrev_q <= 1'h0;
    end else begin
      hStrobePrev_q <= hStrobeS;
    end
  end

  // control fields; a write is taken once per strobe rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      divSel_q <= DIV_RESET;
      srqEn_q  <= SRQ_EN_RESET;
      loop_q   <= LOOP_RESET;
      halt_q   <= HALT_RESET;
    end else if (accStart && hWriteS && hSelS == SEL_CTRL) begin
      divSel_q <= hDataS[CS_DIV_MSB:CS_DIV_LSB];
      srqEn_q  <= hDataS[CS_SRQ_EN_BIT];
      loop_q   <= hDataS[CS_LOOP_BIT];
      halt_q   <= hDataS[CS_HALT_BIT];
    end
  end

  // read data held in a flop, driven only for the addressed board
  always_ff @(posedge clk) begin
    if (rst) begin
      hostDataOut  <= '0;
      hostDataOe_n <= 1'h1;
    end else begin
      hostDataOut  <= (hSelS == SEL_CTRL) ? statusByte : rxData_q;
      hostDataOe_n <= !(hStrobeS && !hWriteS && boardHit);
    end
  end

  assign hostServiceRequest = cableS && !srqEn_q;

  // two-entry write buffer between host port and serial engine
  logic [7:0]     bufMem_q [BUF_DEPTH];
  logic [PTR_W:0] bufCnt_q;
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] rdPtr_q;
  logic           bufInValid;
  logic           bufInReady;
  logic           bufOutValid;
  logic           bufOutReady;
  logic           bufPush;
  logic           bufPop;

  assign bufInValid  = accStart && hWriteS && hSelS == SEL_DATA;
  assign bufInReady  = bufCnt_q != (PTR_W + 1)'(BUF_DEPTH);
  assign bufOutValid = bufCnt_q != '0;
  assign bufPush     = bufInValid && bufInReady;
  assign bufPop      = bufOutValid && bufOutReady;
  assign hostBusy    = !bufInReady;

  always_ff @(posedge clk) begin
    if (rst) begin
      bufCnt_q <= '0;
      wrPtr_q  <= '0;
      rdPtr_q  <= '0;
    end else begin
      bufCnt_q <= bufCnt_q + (PTR_W + 1)'(bufPush) - (PTR_W + 1)'(bufPop);
      if (bufPush) begin
        wrPtr_q <= (wrPtr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (bufPop) begin
        rdPtr_q <= (rdPtr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (bufPush) begin
      bufMem_q[wrPtr_q] <= hDataS;
    end
  end

  // serial clock divider select
  logic [7:0] sclkPer;
  logic [7:0] sclkHalf;
  always_comb begin
    case (divSel_q)
      2'h0:    sclkPer = SCLK_PER_00;
      2'h1:    sclkPer = SCLK_PER_01;
      2'h2:    sclkPer = SCLK_PER_10;
      default: sclkPer = SCLK_PER_11;
    endcase
    sclkHalf = sclkPer >> 1;
  end

  pdb_state_e state_q;
  logic [7:0] phase_q;
  logic [2:0] bitCnt_q;
  logic [7:0] txShift_q;
  logic [7:0] rxShift_q;
  logic [7:0] txByte_q;
  logic       sclk_q;
  logic       sdi_q;
  logic       loopOn;
  logic       procReady;
  logic       rxBit;
  logic       lastPhase;

  assign loopOn      = !loop_q;
  assign procReady   = loopOn || (sdoS == READY_LEVEL);
  assign rxBit       = loopOn ? sdi_q : sdoS;
  assign lastPhase   = phase_q == sclkPer - 8'h01;
  assign bufOutReady = state_q == PDB_IDLE && cableS && !resetSeen;

  // byte engine; data changes at the falling half, sampled on the rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= PDB_IDLE;
      phase_q   <= '0;
      bitCnt_q  <= '0;
      txShift_q <= '0;
      rxShift_q <= '0;
      txByte_q  <= '0;
      rxData_q  <= '0;
      txCut_q   <= 1'h0;
      sclk_q    <= 1'h0;
      sdi_q     <= 1'h0;
    end else begin
      case (state_q)
        PDB_IDLE: begin
          sclk_q <= 1'h0;
          if (bufPop) begin
            txShift_q <= bufMem_q[rdPtr_q];
            txByte_q  <= bufMem_q[rdPtr_q];
            txCut_q   <= 1'h0;
            state_q   <= PDB_WAIT_RDY;
          end
        end
        PDB_WAIT_RDY: begin
          if (!cableS) begin
            state_q <= PDB_IDLE;
          end else if (procReady) begin
            phase_q  <= '0;
            bitCnt_q <= '0;
            sdi_q    <= txShift_q[7];
            state_q  <= PDB_SHIFT;
          end
        end
        PDB_SHIFT: begin
          if (resetSeen && !loopOn) begin
            txCut_q <= 1'h1;
            sclk_q  <= 1'h0;
            state_q <= PDB_IDLE;
          end else if (!cableS) begin
            sclk_q  <= 1'h0;
            state_q <= PDB_IDLE;
          end else begin
            phase_q <= lastPhase ? 8'h00 : phase_q + 8'h01;
            if (phase_q == sclkHalf) begin
              sclk_q    <= 1'h1;
              rxShift_q <= {rxShift_q[6:0], rxBit};
            end
            if (lastPhase) begin
              sclk_q    <= 1'h0;
              txShift_q <= {txShift_q[6:0], 1'h0};
              sdi_q     <= txShift_q[6];
              bitCnt_q  <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'(BITS_PER_BYTE - 1)) begin
                state_q <= PDB_DONE;
              end
            end
          end
        end
        PDB_DONE: begin
          rxData_q <= rxShift_q;
          state_q  <= PDB_IDLE;
        end
        default: state_q <= PDB_IDLE;
      endcase
    end
  end

  // soft reset configuration held a little past release
  logic [3:0] cfgHold_q;
  logic       cfgDrive;
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgHold_q <= '0;
    end else if (!sresetS_n) begin
      cfgHold_q <= CFG_HOLD_CYC;
    end else if (cfgHold_q != '0) begin
      cfgHold_q <= cfgHold_q - 4'h1;
    end
  end
  assign cfgDrive = !sresetS_n || cfgHold_q != '0;

  // pins: config during soft reset, shift data otherwise, all released without cable
  always_ff @(posedge clk) begin
    if (rst) begin
      debugSerialClock     <= 1'h0;
      debugSerialIn        <= 1'h0;
      debugSerialClockOe_n <= 1'h1;
      debugSerialInOe_n    <= 1'h1;
    end else begin
      debugSerialClock     <= cfgDrive ? !halt_q : sclk_q;
      debugSerialIn        <= cfgDrive ? 1'h1 : sdi_q;
      debugSerialClockOe_n <= !cableS;
      debugSerialInOe_n    <= !cableS || loopOn;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_byteStart;
    state_q == PDB_WAIT_RDY && procReady && cableS;
  endsequence
  sequence s_cutMidByte;
    state_q == PDB_SHIFT && resetSeen && !loopOn;
  endsequence

  a_div_reset: assert property ($fell(rst) |-> divSel_q == 2'h0 && !srqEn_q)
    else $error("divider or request enable not cleared by reset");
  a_ready_gate: assert property (
    state_q == PDB_WAIT_RDY && !procReady |=> state_q != PDB_SHIFT)
    else $error("transfer began before processor ready");
  a_cut_flag: assert property (s_cutMidByte |=> txCut_q && state_q == PDB_IDLE)
    else $error("reset mid-byte did not set cut flag");
  a_byte_bits: assert property (
    s_byteStart |=> state_q == PDB_SHIFT && bitCnt_q == 3'h0 && sdi_q == txByte_q[7])
    else $error("byte did not start with its top bit");
  a_loop_echo: assert property (
    state_q == PDB_DONE && loopOn && !txCut_q |=> rxData_q == txByte_q)
    else $error("loopback byte not captured back");
  a_loop_tri: assert property (loopOn |=> debugSerialInOe_n)
    else $error("serial data pin driven in loopback");
  a_cable_off: assert property (
    !cableS |=> debugSerialClockOe_n && debugSerialInOe_n && hostDataOe_n)
    else $error("outputs driven without cable");
  a_sample_rise: assert property (
    state_q == PDB_SHIFT && phase_q == sclkHalf && !resetSeen && cableS
    |-> $stable(sdi_q) ##1 sclk_q)
    else $error("serial data moved at clock rise");
  a_status_view: assert property (
    hStrobeS && !hWriteS && hSelS == SEL_CTRL
    |=> hostDataOut[CS_IN_DEBUG_BIT] == $past(&frzS)
        && hostDataOut[CS_RESET_SEEN_BIT] == $past(resetSeen))
    else $error("status byte does not reflect processor state");
  a_srq_level: assert property (accStart && hWriteS && hSelS == SEL_CTRL
    |=> !cableS || hostServiceRequest == !$past(hDataS[CS_SRQ_EN_BIT]))
    else $error("service request level wrong");

endmodule

// ### rtl/pdb_pkg.sv
// constants shared by the parallel-to-serial debug bridge
// assumes a 250 MHz core clock; all pin inputs are asynchronous
package pdb_pkg;

  // core clock rate and the four serial clock rates
  localparam int CLK_FREQ_KHZ   = 250000;
  localparam int SCLK_KHZ_00    = 10000;
  localparam int SCLK_KHZ_01    = 5000;
  localparam int SCLK_KHZ_10    = 2500;
  localparam int SCLK_KHZ_11    = 1250;
  // one serial clock period in core cycles
  localparam logic [7:0] SCLK_PER_00 = 8'(CLK_FREQ_KHZ / SCLK_KHZ_00);
  localparam logic [7:0] SCLK_PER_01 = 8'(CLK_FREQ_KHZ / SCLK_KHZ_01);
  localparam logic [7:0] SCLK_PER_10 = 8'(CLK_FREQ_KHZ / SCLK_KHZ_10);
  localparam logic [7:0] SCLK_PER_11 = 8'(CLK_FREQ_KHZ / SCLK_KHZ_11);

  // control/status field positions
  localparam int CS_RESET_SEEN_BIT = 7;
  localparam int CS_TX_CUT_BIT     = 6;
  localparam int CS_IN_DEBUG_BIT   = 5;
  localparam int CS_DIV_MSB        = 4;
  localparam int CS_DIV_LSB        = 3;
  localparam int CS_SRQ_EN_BIT     = 2;
  localparam int CS_LOOP_BIT       = 1;
  localparam int CS_HALT_BIT       = 0;

  // interface reset values of the writable fields
  localparam logic [1:0] DIV_RESET     = 2'h0;
  localparam logic       SRQ_EN_RESET  = 1'h0;
  localparam logic       LOOP_RESET    = 1'h0;
  localparam logic       HALT_RESET    = 1'h0;

  // register select levels on the host port
  localparam logic SEL_CTRL = 1'h0;
  localparam logic SEL_DATA = 1'h1;

  // cycles the reset configuration is held after soft reset release
  localparam logic [3:0] CFG_HOLD_CYC = 4'hc;

  localparam int BITS_PER_BYTE = 8;

  typedef enum {PDB_IDLE, PDB_WAIT_RDY, PDB_SHIFT, PDB_DONE} pdb_state_e;

endpackage

// ### tb/pdb_cpu_model.sv
// processor debug port model: full duplex shift on the serial clock
// assumes the bench pulls clock and data wires low while the bridge floats them
`timescale 1ns/1ps
module pdb_cpu_model
  import pdb_pkg::*;
#(
  parameter logic READY_LEVEL = 1'h0
) (
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       rstN,
  input  wire logic       stall,
  input  wire logic [7:0] reply,
  output logic            sdo,
  output logic [7:0]      got,
  output int              nBytes
);
  logic [2:0] cnt;
  logic [7:0] sh;
  initial begin
    cnt = 3'h0;
    sh = 8'h00;
    got = 8'h00;
    nBytes = 0;
  end
  // capture on the rising edge, next reply bit follows it
  always @(posedge sclk or negedge rstN) begin
    if (!rstN) begin
      cnt <= 3'h0;
    end else begin
      sh <= {sh[6:0], sdi};
      cnt <= cnt + 3'h1;
      if (cnt == 3'h7) begin
        got <= {sh[6:0], sdi};
        nBytes <= nBytes + 1;
      end
    end
  end
  // reply msb is kept at ready level, so idle reads as ready
  assign sdo = stall ? ~READY_LEVEL : reply[3'h7 - cnt];
endmodule

// ### tb/test_pdb_bridge.sv
// bench for the parallel to serial debug bridge
// assumes the processor model answers on the pulled-down serial wires
`timescale 1ns/1ps
module test_pdb_bridge
  import pdb_pkg::*;
  ;
  logic       clk = 0, rst = 1, hostStrobe = 0, hostWrite = 0, registerSelectLine = 0;
  logic [7:0] hostDataIn = 8'h00, hostDataOut, q, got, reply = 8'h30;
  logic [2:0] hostBoardAddr = 3'h2, boardSelectSwitch = 3'h2;
  logic       cableConnected = 1, hostDataOe_n, hostServiceRequest, hostBusy, oe;
  logic       debugSerialClock, debugSerialClockOe_n, debugSerialIn, debugSerialInOe_n;
  logic       debugSerialOut, softResetLine_n = 1, hardResetLine_n = 1, stall = 0, prevSclk;
  logic [1:0] freezeStatusPair = 2'h0;
  logic       sclkW, sdiW;
  int         failures = 0, compares = 0, cyc = 0, perCnt = 0, lastPer = 0, nRise = 0, nBytes;
  int         per[3] = '{25, 50, 100};

  // floating wires settle low through the target pull-downs
  assign sclkW = debugSerialClockOe_n ? 1'b0 : debugSerialClock;
  assign sdiW  = debugSerialInOe_n ? 1'b0 : debugSerialIn;

  pdb_bridge dut (.clk(clk), .rst(rst), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe_n(hostDataOe_n), .hostStrobe(hostStrobe), .hostWrite(hostWrite),
    .registerSelectLine(registerSelectLine), .hostBoardAddr(hostBoardAddr),
    .boardSelectSwitch(boardSelectSwitch), .cableConnected(cableConnected),
    .hostServiceRequest(hostServiceRequest), .hostBusy(hostBusy),
    .debugSerialClock(debugSerialClock), .debugSerialClockOe_n(debugSerialClockOe_n),
    .debugSerialIn(debugSerialIn), .debugSerialInOe_n(debugSerialInOe_n),
    .debugSerialOut(debugSerialOut), .freezeStatusPair(freezeStatusPair),
    .softResetLine_n(softResetLine_n), .hardResetLine_n(hardResetLine_n));

  pdb_cpu_model cpu (.sclk(sclkW), .sdi(sdiW), .rstN(softResetLine_n), .stall(stall),
    .reply(reply), .sdo(debugSerialOut), .got(got), .nBytes(nBytes));

  always #2 clk = ~clk;

  always @(posedge clk) begin
    prevSclk <= sclkW;
    perCnt <= perCnt + 1;
    if (sclkW && !prevSclk) begin
      lastPer <= perCnt;
      perCnt <= 1;
      nRise <= nRise + 1;
    end
  end

  // whole run needs well under half of this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // hold select, direction and data well around the synced strobe
  task automatic acc(input logic sel, input logic wr, input logic [7:0] d);
    registerSelectLine = sel;
    hostWrite = wr;
    hostDataIn = d;
    repeat (3) @(posedge clk);
    #1 hostStrobe = 1;
    repeat (5) @(posedge clk);
    #1 q = hostDataOut;
    oe = hostDataOe_n;
    hostStrobe = 0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic wait_byte(input int n);
    int k;
    k = 0;
    while (nBytes < n && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk("byte done", 8'(nBytes >= n), 8'h01);
    // received byte lands half a slow period after the model's last rise
    repeat (110) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    acc(0, 0, 8'h00);
    chk("status reset", q, 8'h00);
    chk("status oe", oe, 0);
    chk("service req", hostServiceRequest, 1);
    chk("sdi float", debugSerialInOe_n, 1);
    $display("done reset");
  endtask

  task automatic t_loop();
    acc(1, 1, 8'ha5);
    repeat (240) @(posedge clk);
    #1 acc(1, 0, 8'h00);
    chk("loop data", q, 8'ha5);
    $display("done loopback");
  endtask

  task automatic t_ctrl();
    acc(0, 1, 8'h07);
    acc(0, 0, 8'h00);
    chk("ctrl rw", q, 8'h07);
    chk("no request", hostServiceRequest, 0);
    chk("sdi driven", debugSerialInOe_n, 0);
    chk("sclk driven", debugSerialClockOe_n, 0);
    $display("done control");
  endtask

  task automatic t_rates();
    int n;
    for (int c = 0; c < 3; c++) begin
      acc(0, 1, {3'h0, 2'(c), 3'h7});
      reply = 8'h30 | 8'(c);
      n = nBytes;
      acc(1, 1, 8'hc3 ^ 8'(c));
      wait_byte(n + 1);
      chk("sclk period", 8'(lastPer), 8'(per[c]));
      chk("tx byte", got, 8'hc3 ^ 8'(c));
      acc(1, 0, 8'h00);
      chk("rx byte", q, reply);
    end
    $display("done rates");
  endtask

  task automatic t_stall();
    int n, r;
    acc(0, 1, 8'h07);
    stall = 1;
    n = nBytes;
    r = nRise;
    acc(1, 1, 8'h11);
    acc(1, 1, 8'h22);
    acc(1, 1, 8'h33);
    chk("busy full", hostBusy, 1);
    acc(1, 1, 8'h44);
    chk("held off", 8'(nRise == r), 8'h01);
    stall = 0;
    wait_byte(n + 3);
    chk("last kept", got, 8'h33);
    chk("busy clear", hostBusy, 0);
    repeat (300) @(posedge clk);
    #1 chk("drop count", 8'(nBytes - n), 8'h03);
    $display("done stall");
  endtask

  task automatic t_status();
    freezeStatusPair = 2'h3;
    acc(0, 0, 8'h00);
    chk("in debug", q[5], 1);
    freezeStatusPair = 2'h2;
    acc(0, 0, 8'h00);
    chk("half freeze", q[5], 0);
    hardResetLine_n = 0;
    acc(0, 0, 8'h00);
    chk("hard seen", q[7], 1);
    hardResetLine_n = 1;
    freezeStatusPair = 2'h0;
    $display("done status");
  endtask

  task automatic t_cut();
    int n;
    acc(0, 1, 8'h17);
    acc(1, 1, 8'h5a);
    repeat (400) @(posedge clk);
    #1 softResetLine_n = 0;
    repeat (6) @(posedge clk);
    #1 chk("cfg clock", debugSerialClock, 0);
    chk("cfg data", debugSerialIn, 1);
    acc(0, 0, 8'h00);
    chk("soft seen", q[7], 1);
    softResetLine_n = 1;
    repeat (30) @(posedge clk);
    #1 acc(0, 0, 8'h00);
    chk("cut flag", q[6], 1);
    n = nBytes;
    acc(1, 1, 8'h0f);
    wait_byte(n + 1);
    acc(0, 0, 8'h00);
    chk("cut cleared", q[6], 0);
    acc(0, 1, 8'h16);
    softResetLine_n = 0;
    repeat (6) @(posedge clk);
    #1 chk("halt clock", debugSerialClock, 1);
    softResetLine_n = 1;
    repeat (30) @(posedge clk);
    #1 $display("done cut");
  endtask

  task automatic t_gate();
    hostBoardAddr = 3'h5;
    acc(0, 1, 8'h00);
    acc(0, 0, 8'h00);
    chk("other board", oe, 1);
    hostBoardAddr = 3'h2;
    acc(0, 0, 8'h00);
    chk("ctrl kept", q[4:0], 8'h16);
    acc(0, 1, 8'h00);
    cableConnected = 0;
    repeat (5) @(posedge clk);
    #1 chk("pins float", {debugSerialClockOe_n, debugSerialInOe_n, hostServiceRequest}, 6);
    acc(0, 0, 8'h00);
    chk("host float", oe, 1);
    cableConnected = 1;
    $display("done gating");
  endtask

  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    repeat (3) @(posedge clk);
    #1 t_reset();
    t_loop();
    t_ctrl();
    t_rates();
    t_stall();
    t_status();
    t_cut();
    t_gate();
    wrap_up();
  end
endmodule
